// *** hw/cmd_frame_pkg.sv ***
// constants shared by both ends of the command frame link
// assumes a single sys_clk domain on both ends
package cmd_frame_pkg;
   localparam logic [1:0] frame_type_command = 2'h2;
   localparam logic [0:0] ack_none = 1'h0;
   localparam logic [0:0] ack_immediate = 1'h1;
   typedef enum logic [3:0] {
      sub_reserve_req = 4'h0,
      sub_reserve_rsp = 4'h1,
      sub_probe = 4'h2,
      sub_pairwise_key = 4'h3,
      sub_group_key = 4'h4,
      sub_link_feedback = 4'h5,
      sub_relay = 4'h6,
      sub_diversity_set_req = 4'h7,
      sub_diversity_set_rsp = 4'h8,
      sub_unequal_map = 4'h9,
      sub_diversity_switch = 4'ha,
      sub_channel_select = 4'hb,
      sub_app_specific = 4'he
   } subtype_e;
   typedef enum logic [1:0] {
      chan_scan_req = 2'h0,
      chan_scan_rsp = 2'h1,
      chan_change_req = 2'h2,
      chan_change_rsp = 2'h3
   } chan_cmd_e;
   // channel selection control field layout
   localparam int cmd_msb = 15;
   localparam int cmd_lsb = 14;
   localparam int resv_msb = 13;
   localparam int resv_lsb = 12;
   localparam int reason_msb = 11;
   localparam int reason_lsb = 10;
   localparam int bitmap_msb = 9;
   localparam int bitmap_width = 10;
   // availability element length bounds, octets
   localparam logic [5:0] avail_min_len = 6'h02;
   localparam logic [5:0] avail_max_len = 6'h22;
   localparam int addr_width = 16;
   // header byte order on the link: type/subtype/ack, dst hi, dst lo, src hi, src lo
   localparam logic [2:0] hdr_len = 3'h5;
endpackage

// *** hw/cmd_frame_if.sv ***
// byte stream carrying command frames between the two ends
// assumes both ends share sys_clk; bytes move on valid and ready
`timescale 1ns/10ps
interface cmd_frame_if;
   logic [7:0] data;
   logic valid;
   logic ready;
   logic last;
   modport tx (output data, output valid, output last, input ready);
   modport rx (input data, input valid, input last, output ready);
endinterface

// *** hw/cmd_frame_tx.sv ***
// transmit end: builds command frame header, channel selection control and payload bytes
// assumes the user holds its request stable until tx_done pulses
//
// What this block does
// - frame type two, defined subtype only
// - destination address holds recipient device address
// - source address holds own device address
// - subtypes 0,1 mean reservation request, response
// - subtype 2 means probe command
// - subtypes 3,4 mean pairwise, group key
// - subtypes 5,6 mean link feedback, relay
// - subtypes 7,8,10 mean diversity set, switch
// - subtype 9 means unequal protection map
// - 11 channel select, 14 application; rest reserved
// - reservation request is list of reservation elements
// - response repeats elements, then availability element
// - channel selection frames request immediate acknowledgement
// - channel payload: control word, then elements
// - control bits: cmd, reserved, reason, bitmap
// - command ids scan req/rsp, change req/rsp
// - bitmap bit n is channel n+1
// - ack policy zero none, one immediate
// - scan request sets exactly requested channels
`timescale 1ns/10ps
module cmd_frame_tx #(
   parameter int addr_width = cmd_frame_pkg::addr_width
) (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic tx_start,
   input wire logic [3:0] tx_subtype,
   input wire logic tx_ack_req,
   input wire logic [addr_width-1:0] destination_address,
   input wire logic [addr_width-1:0] device_address,
   input wire logic [1:0] chan_cmd,
   input wire logic [1:0] chan_reason,
   input wire logic [9:0] chan_bitmap,
   input wire logic [7:0] pay_data,
   input wire logic pay_valid,
   input wire logic pay_last,
   output logic pay_ready,
   output logic tx_busy_reg,
   output logic tx_done_reg,
   output logic tx_reject_reg,
   cmd_frame_if.tx link
);
   typedef enum logic [2:0] {
      st_idle = 3'h0,
      st_hdr = 3'h1,
      st_ctl_hi = 3'h2,
      st_ctl_lo = 3'h3,
      st_pay = 3'h4
   } tx_state_e;
   tx_state_e state_reg;
   logic [2:0] idx_reg;
   logic [7:0] hdr_byte;
   logic [15:0] ctl_word;
   logic subtype_ok;
   logic is_chan;
   logic [1:0] ctl_reason;
   logic [9:0] ctl_bitmap;
   logic take;
   logic [7:0] data_reg;
   logic valid_reg;
   logic last_reg;

   // only defined command subtypes leave this end; 12,13,15 are refused
   assign subtype_ok = (tx_subtype <= 4'hb) || (tx_subtype == 4'he);
   assign is_chan = (tx_subtype == cmd_frame_pkg::sub_channel_select);
   assign take = !valid_reg || link.ready;

   // fields reserved for a given command are forced to zero
   always_comb begin
      ctl_reason = chan_reason;
      ctl_bitmap = chan_bitmap;
      if (chan_cmd != cmd_frame_pkg::chan_change_rsp) begin
         ctl_reason = 2'h0;
      end
      if (chan_cmd[1]) begin
         ctl_bitmap = 10'h000;
      end
      ctl_word = {chan_cmd, 2'h0, ctl_reason, ctl_bitmap};
   end

   // header bytes in link order
   always_comb begin
      unique case (idx_reg)
         3'h0: hdr_byte = {cmd_frame_pkg::frame_type_command, tx_subtype,
            1'h0, is_chan ? cmd_frame_pkg::ack_immediate : tx_ack_req};
         3'h1: hdr_byte = destination_address[15:8];
         3'h2: hdr_byte = destination_address[7:0];
         3'h3: hdr_byte = device_address[15:8];
         default: hdr_byte = device_address[7:0];
      endcase
   end

   // payload bytes are passed through only while the link accepts them
   assign pay_ready = (state_reg == st_pay) && take;

   // frame sequencer
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= st_idle;
         idx_reg <= 3'h0;
      end else begin
         unique case (state_reg)
            st_idle: begin
               idx_reg <= 3'h0;
               if (tx_start && subtype_ok) begin
                  state_reg <= st_hdr;
               end
            end
            st_hdr: begin
               if (take) begin
                  idx_reg <= idx_reg + 3'h1;
                  if (idx_reg == cmd_frame_pkg::hdr_len - 3'h1) begin
                     state_reg <= is_chan ? st_ctl_hi : st_pay;
                  end
               end
            end
            st_ctl_hi: if (take) begin
               state_reg <= st_ctl_lo;
            end
            st_ctl_lo: if (take) begin
               state_reg <= st_pay;
            end
            // element list supplied by user, framed until pay_last
            st_pay: if (take && pay_valid && pay_last) begin
               state_reg <= st_idle;
            end
            default: state_reg <= st_idle;
         endcase
      end
   end

   // link output byte register
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         data_reg <= 8'h00;
         valid_reg <= 1'b0;
         last_reg <= 1'b0;
      end else if (take) begin
         valid_reg <= 1'b0;
         last_reg <= 1'b0;
         unique case (state_reg)
            st_idle: data_reg <= data_reg;
            st_hdr: begin
               data_reg <= hdr_byte;
               valid_reg <= 1'b1;
            end
            st_ctl_hi: begin
               data_reg <= ctl_word[15:8];
               valid_reg <= 1'b1;
            end
            st_ctl_lo: begin
               data_reg <= ctl_word[7:0];
               valid_reg <= 1'b1;
            end
            default: begin
               data_reg <= pay_data;
               valid_reg <= pay_valid;
               last_reg <= pay_valid && pay_last;
            end
         endcase
      end
   end

   // status flags toward the user
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         tx_busy_reg <= 1'b0;
         tx_done_reg <= 1'b0;
         tx_reject_reg <= 1'b0;
      end else begin
         tx_busy_reg <= (state_reg != st_idle);
         tx_done_reg <= (state_reg == st_pay) && take && pay_valid && pay_last;
         tx_reject_reg <= (state_reg == st_idle) && tx_start && !subtype_ok;
      end
   end

   assign link.data = data_reg;
   assign link.valid = valid_reg;
   assign link.last = last_reg;
endmodule

// *** hw/cmd_frame_rx.sv ***
// receive end: parses command frame header and channel selection control field
// assumes frames arrive on the shared byte stream, last marks the final byte
`timescale 1ns/10ps
module cmd_frame_rx #(
   parameter int addr_width = cmd_frame_pkg::addr_width
) (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic [addr_width-1:0] device_address,
   output logic hdr_valid_reg,
   output logic [3:0] rx_subtype_reg,
   output logic rx_ack_req_reg,
   output logic [addr_width-1:0] rx_source_reg,
   output logic rx_bad_reg,
   output logic ctl_valid_reg,
   output logic [1:0] rx_chan_cmd_reg,
   output logic [1:0] rx_reason_reg,
   output logic [9:0] rx_bitmap_reg,
   output logic [7:0] pay_data_reg,
   output logic pay_valid_reg,
   output logic pay_last_reg,
   cmd_frame_if.rx link
);
   logic [2:0] cnt_reg;
   logic [7:0] b0_reg;
   logic [15:0] dst_reg;
   logic [7:0] ctl_hi_reg;
   logic is_chan;
   logic beat;
   logic pay_beat;
   logic hdr_end;
   logic good;

   assign link.ready = 1'b1;
   assign beat = link.valid;
   // byte 0 carries type in 7:6, subtype in 5:2 and ack policy in 0
   assign is_chan = (b0_reg[5:2] == cmd_frame_pkg::sub_channel_select);
   assign hdr_end = beat && cnt_reg == 3'h4;
   // frame is for us, is a command frame, and uses a defined subtype
   assign good = (b0_reg[7:6] == cmd_frame_pkg::frame_type_command) &&
      (dst_reg == device_address) && ((b0_reg[5:2] <= 4'hb) || (b0_reg[5:2] == 4'he));
   assign pay_beat = beat && (cnt_reg == 3'h7 || (cnt_reg == 3'h5 && !is_chan));

   // byte position within frame; saturates in payload
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_reg <= 3'h0;
         b0_reg <= 8'h00;
         dst_reg <= 16'h0000;
         ctl_hi_reg <= 8'h00;
      end else if (beat) begin
         if (link.last) begin
            cnt_reg <= 3'h0;
         end else if (cnt_reg == 3'h5 && !is_chan) begin
            cnt_reg <= 3'h5;
         end else if (cnt_reg != 3'h7) begin
            cnt_reg <= cnt_reg + 3'h1;
         end
         if (cnt_reg == 3'h0) b0_reg <= link.data;
         if (cnt_reg == 3'h1) dst_reg[15:8] <= link.data;
         if (cnt_reg == 3'h2) dst_reg[7:0] <= link.data;
         if (cnt_reg == 3'h5) ctl_hi_reg <= link.data;
      end
   end

   // header fields
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         hdr_valid_reg <= 1'b0;
         rx_bad_reg <= 1'b0;
         rx_subtype_reg <= 4'h0;
         rx_ack_req_reg <= 1'b0;
         rx_source_reg <= '0;
      end else begin
         hdr_valid_reg <= hdr_end && good;
         rx_bad_reg <= hdr_end && !good;
         if (cnt_reg == 3'h3 && beat) rx_source_reg[15:8] <= link.data;
         if (hdr_end) begin
            rx_source_reg[7:0] <= link.data;
            rx_subtype_reg <= b0_reg[5:2];
            rx_ack_req_reg <= b0_reg[0];
         end
      end
   end

   // channel selection control, reserved bits 13:12 dropped
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         ctl_valid_reg <= 1'b0;
         rx_chan_cmd_reg <= 2'h0;
         rx_reason_reg <= 2'h0;
         rx_bitmap_reg <= 10'h000;
      end else begin
         ctl_valid_reg <= beat && is_chan && cnt_reg == 3'h6;
         if (beat && is_chan && cnt_reg == 3'h6) begin
            rx_chan_cmd_reg <= ctl_hi_reg[7:6];
            rx_reason_reg <= ctl_hi_reg[3:2];
            rx_bitmap_reg <= {ctl_hi_reg[1:0], link.data};
         end
      end
   end

   // element bytes forwarded one cycle late
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         pay_data_reg <= 8'h00;
         pay_valid_reg <= 1'b0;
         pay_last_reg <= 1'b0;
      end else begin
         pay_valid_reg <= pay_beat;
         pay_last_reg <= pay_beat && link.last;
         if (pay_beat) pay_data_reg <= link.data;
      end
   end
endmodule

// *** dv/cmd_frame_props.sv ***
// checker on the byte stream that joins the two command frame ends
// assumes one sys_clk domain; byte 0 of a frame is type, subtype and ack
`timescale 1ns/10ps
module cmd_frame_props (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic [7:0] data,
   input wire logic valid,
   input wire logic ready,
   input wire logic last
);
   logic [3:0] idx_reg;
   logic [3:0] sub_reg;
   logic [1:0] cmd_reg;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   // byte position, saturating so a long payload never wraps back into the header
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) idx_reg <= 4'h0;
      else if (valid && ready) idx_reg <= last ? 4'h0 : idx_reg + {3'h0, idx_reg != 4'hf};
   end
   // subtype and control command kept for the bytes that follow them
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         sub_reg <= 4'h0;
         cmd_reg <= 2'h0;
      end else if (valid && ready && idx_reg == 4'h0) sub_reg <= data[5:2];
      else if (valid && ready && idx_reg == 4'h5) cmd_reg <= data[7:6];
   end
   sequence s_head;
      valid && idx_reg == 4'h0;
   endsequence
   sequence s_ctl_hi;
      valid && sub_reg == 4'hb && idx_reg == 4'h5;
   endsequence
   sequence s_ctl_lo;
      valid && sub_reg == 4'hb && idx_reg == 4'h6;
   endsequence
   a_type_cmd: assert property (s_head |-> data[7:6] == cmd_frame_pkg::frame_type_command)
      else $error("frame type not command");
   a_sub_defined: assert property (s_head |-> !(data[5:2] inside {4'hc, 4'hd, 4'hf}))
      else $error("reserved subtype sent");
   a_chsel_ack: assert property (s_head ##0 data[5:2] == 4'hb |-> data[0] == cmd_frame_pkg::ack_immediate)
      else $error("channel selection without immediate ack");
   a_resv_zero: assert property (s_ctl_hi |-> data[5:4] == 2'h0)
      else $error("reserved control bits not zero");
   a_reason_zero: assert property (s_ctl_hi ##0 data[7:6] != 2'h3 |-> data[3:2] == 2'h0)
      else $error("reason code set outside change response");
   a_bitmap_zero: assert property (s_ctl_lo ##0 cmd_reg[1] |-> data == 8'h00)
      else $error("bitmap set in change command");
   a_bitmap_hi: assert property (s_ctl_hi ##0 data[7] |-> data[1:0] == 2'h0)
      else $error("upper bitmap bits set in change command");
   a_hdr_whole: assert property (valid && idx_reg < 4'h5 |-> !last)
      else $error("frame ends inside header");
   a_ctl_whole: assert property (valid && sub_reg == 4'hb && idx_reg inside {4'h5, 4'h6} |-> !last)
      else $error("frame ends inside control word");
endmodule

// *** dv/mac_command_frame_codec_tb.sv ***
// self-checking bench: transmit end feeds receive end over the byte stream
// assumes both ends share sys_clk; receive end keeps ready high
`timescale 1ns/10ps
module mac_command_frame_codec_tb;
   localparam logic [15:0] rx_addr = 16'h5a21;
   logic sys_clk = 1'b0;
   logic arst_n = 1'b0;
   logic tx_start = 1'b0;
   logic [3:0] tx_subtype = 4'h0;
   logic tx_ack_req = 1'b0;
   logic [15:0] own_addr = 16'h0c3e;
   logic [15:0] dst_addr = rx_addr;
   logic [1:0] chan_cmd = 2'h0;
   logic [1:0] chan_reason = 2'h0;
   logic [9:0] chan_bitmap = 10'h000;
   logic [7:0] pay_data = 8'h00;
   logic pay_valid = 1'b0;
   logic pay_last = 1'b0;
   logic pay_ready, tx_done_reg, tx_reject_reg, hdr_valid_reg, rx_ack_req_reg, rx_bad_reg;
   logic ctl_valid_reg, pay_valid_reg, pay_last_reg;
   logic tx_busy_reg;
   logic [3:0] rx_subtype_reg;
   logic [15:0] rx_source_reg;
   logic [1:0] rx_chan_cmd_reg, rx_reason_reg;
   logic [9:0] rx_bitmap_reg;
   logic [7:0] pay_data_reg;
   int mismatches = 0;
   int checks_done = 0;
   logic [20:0] hdr_q[$];
   logic [13:0] ctl_q[$];
   logic [8:0] pay_q[$];
   logic done_q[$];
   logic bad_q[$];
   always #20 sys_clk = ~sys_clk;
   cmd_frame_if cmd_frame_if_inst ();
   cmd_frame_tx cmd_frame_tx_inst (.sys_clk(sys_clk), .arst_n(arst_n), .tx_start(tx_start), .tx_subtype(tx_subtype),
      .tx_ack_req(tx_ack_req), .destination_address(dst_addr), .device_address(own_addr), .chan_cmd(chan_cmd),
      .chan_reason(chan_reason), .chan_bitmap(chan_bitmap), .pay_data(pay_data), .pay_valid(pay_valid),
      .pay_last(pay_last), .pay_ready(pay_ready), .tx_busy_reg(tx_busy_reg), .tx_done_reg(tx_done_reg),
      .tx_reject_reg(tx_reject_reg), .link(cmd_frame_if_inst.tx));
   cmd_frame_rx cmd_frame_rx_inst (.sys_clk(sys_clk), .arst_n(arst_n), .device_address(rx_addr),
      .hdr_valid_reg(hdr_valid_reg), .rx_subtype_reg(rx_subtype_reg), .rx_ack_req_reg(rx_ack_req_reg),
      .rx_source_reg(rx_source_reg), .rx_bad_reg(rx_bad_reg), .ctl_valid_reg(ctl_valid_reg),
      .rx_chan_cmd_reg(rx_chan_cmd_reg), .rx_reason_reg(rx_reason_reg), .rx_bitmap_reg(rx_bitmap_reg),
      .pay_data_reg(pay_data_reg), .pay_valid_reg(pay_valid_reg), .pay_last_reg(pay_last_reg),
      .link(cmd_frame_if_inst.rx));
   cmd_frame_props cmd_frame_props_inst (.sys_clk(sys_clk), .arst_n(arst_n), .data(cmd_frame_if_inst.data),
      .valid(cmd_frame_if_inst.valid), .ready(cmd_frame_if_inst.ready), .last(cmd_frame_if_inst.last));
   task automatic cmp(input string what, input logic [20:0] exp, input logic [20:0] got);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // one compare task per kind of result; an empty queue hands x so a stray result cannot pass
   task automatic cmp_header();
      cmp("header", hdr_q.size() > 0 ? hdr_q.pop_front() : 21'hx,
         {rx_subtype_reg, rx_ack_req_reg, rx_source_reg});
   endtask
   task automatic cmp_control();
      cmp("control", ctl_q.size() > 0 ? 21'(ctl_q.pop_front()) : 21'hx,
         21'({rx_chan_cmd_reg, rx_reason_reg, rx_bitmap_reg}));
   endtask
   task automatic cmp_payload();
      cmp("payload", pay_q.size() > 0 ? 21'(pay_q.pop_front()) : 21'hx, 21'({pay_last_reg, pay_data_reg}));
   endtask
   task automatic cmp_status();
      cmp("reject", done_q.size() > 0 ? 21'(done_q.pop_front()) : 21'hx, 21'(tx_reject_reg));
   endtask
   task automatic cmp_bad();
      cmp("bad", bad_q.size() > 0 ? 21'(bad_q.pop_front()) : 21'hx, 21'(rx_bad_reg));
   endtask
   task automatic cmp_busy(input logic exp, input logic got);
      cmp("busy", 21'(exp), 21'(got));
   endtask
   task automatic cmp_pending(input logic [20:0] got);
      cmp("pending", 21'h0, got);
   endtask
   // monitor: each result that shows takes the oldest note of its kind
   always @(negedge sys_clk) begin
      if ((hdr_valid_reg | rx_bad_reg) !== 1'b0) cmp_bad();
      if (hdr_valid_reg !== 1'b0) cmp_header();
      if (ctl_valid_reg !== 1'b0) cmp_control();
      if (pay_valid_reg !== 1'b0) cmp_payload();
      if ((tx_done_reg | tx_reject_reg) !== 1'b0) cmp_status();
   end
   // one frame, entered at a falling edge; payload held until ready is sampled
   task automatic send(input logic [3:0] sub);
      int n;
      int k;
      logic took;
      logic fin;
      logic seen_busy;
      logic resv;
      logic [7:0] bytes[4];
      // an edge passes first, so start and valid never drop and rise in one time step
      @(negedge sys_clk);
      n = 1 + $urandom % 3;
      k = 0;
      fin = 1'b0;
      seen_busy = 1'b0;
      resv = sub inside {4'hc, 4'hd, 4'hf};
      for (int i = 0; i < 4; i++) bytes[i] = 8'($urandom);
      tx_subtype = sub;
      done_q.push_back(resv);
      if (!resv) begin
         // a frame for someone else is flagged bad, yet control and payload still pass through
         bad_q.push_back(dst_addr != rx_addr);
         if (dst_addr == rx_addr) hdr_q.push_back({sub, sub == 4'hb ? 1'b1 : tx_ack_req, own_addr});
         if (sub == 4'hb) ctl_q.push_back({chan_cmd, chan_cmd == 2'h3 ? chan_reason : 2'h0,
            chan_cmd[1] ? 10'h000 : chan_bitmap});
         for (int i = 0; i < n; i++) pay_q.push_back({i == n - 1, bytes[i]});
      end
      tx_start = 1'b1;
      pay_valid = 1'b1;
      pay_data = bytes[0];
      pay_last = n == 1;
      for (int c = 0; c < 200 && !fin; c++) begin
         #19 took = pay_valid & pay_ready;
         @(negedge sys_clk);
         fin = tx_done_reg | tx_reject_reg;
         seen_busy = seen_busy | tx_busy_reg;
         tx_start = 1'b0;
         if (took) k++;
         pay_valid = k < n && !fin;
         pay_data = bytes[k % 4];
         pay_last = k == n - 1;
      end
      // a refused subtype must never start a frame
      cmp_busy(!resv, seen_busy);
      if (!fin) begin
         mismatches++;
         print_verdict();
      end
   endtask
   initial begin
      void'($urandom(32'h12f0));
      repeat (6) @(posedge sys_clk);
      @(negedge sys_clk);
      arst_n = 1'b1;
      // every subtype code, then every channel selection command, back to back
      for (int s = 0; s < 20; s++) begin
         tx_ack_req = 1'($urandom);
         own_addr = 16'($urandom);
         dst_addr = ($urandom % 4 == 0) ? 16'($urandom) : rx_addr;
         chan_cmd = 2'(s);
         chan_reason = 2'($urandom);
         chan_bitmap = 10'($urandom);
         send(s < 16 ? 4'(s) : 4'hb);
      end
      repeat (10) @(negedge sys_clk);
      cmp_pending(21'(hdr_q.size() + ctl_q.size() + pay_q.size() + done_q.size() + bad_q.size()));
      cmp_busy(1'b0, tx_busy_reg);
      print_verdict();
   end
endmodule
